// file: include/lpd_defines.svh
// Constants for the line unit pin mode decode block
// Notes on behaviour
// R1: Host mode, clear input low returns command configuration to its defaults.
// R2: Clear input is pulled high inside, so an open pin never clears.
// R3: Hardware mode, invert select low: receive data launched on recovered clock rise.
// R4: Hardware mode, invert select high: receive data launched on recovered clock fall.
// R5: Equalizer-off high disables the receive equalizer; low enables it.
// R6: Loss threshold select picks one of two threshold pairs, DS3 or STS-1 only.
// R7: Near high, far low selects analog local loopback.
// R8: Near and far both high selects digital local loopback.
// R9: Host mode ignores equalizer-off and near loopback pins; board ties them low.
// R10: Far high, near low selects remote loopback.
// R11: Mode select high is host mode, low is hardware pin mode.
// R12: Hardware mode, both loopback pins low means no loopback.
`ifndef LPD_DEFINES_SVH
`define LPD_DEFINES_SVH

// ----------------------------------------------------------------
// Synchronised pin vector positions
// ----------------------------------------------------------------
`define LPD_NPINS       8
`define LPD_PIN_HOST    0
`define LPD_PIN_CLEAR   1
`define LPD_PIN_NEAR    2
`define LPD_PIN_FAR     3
`define LPD_PIN_EQOFF   4
`define LPD_PIN_THR     5
`define LPD_PIN_E3      6
`define LPD_PIN_STS1    7
`define LPD_PINS_RESET  8'h02

// ----------------------------------------------------------------
// Host command configuration word
// ----------------------------------------------------------------
`define LPD_CFG_W       5
`define LPD_CFG_FAR     0
`define LPD_CFG_NEAR    1
`define LPD_CFG_EQOFF   2
`define LPD_CFG_RCLKINV 3
`define LPD_CFG_THR     4
`define LPD_CFG_DEFAULT 5'h00

`endif

// file: include/lpd_pkg.sv
// Types for the line unit pin mode decode block
package lpd_pkg;

  // Loopback selection, coded as {near, far}
  typedef enum logic [1:0] {
    LPD_LOOP_NONE    = 2'b00,
    LPD_LOOP_REMOTE  = 2'b01,
    LPD_LOOP_ANALOG  = 2'b10,
    LPD_LOOP_DIGITAL = 2'b11
  } lpd_loop_type;

  // Line rate
  typedef enum logic [1:0] {
    LPD_RATE_DS3  = 2'b00,
    LPD_RATE_STS1 = 2'b01,
    LPD_RATE_E3   = 2'b10
  } lpd_rate_type;

endpackage : lpd_pkg

// file: include/lpd_launch_if.sv
// Carrier between the decode core and the receive launch stage
`timescale 1ns/1ps
`default_nettype none
interface lpd_launch_if;
  logic launch_on_fall;
  logic rec_clk_en;
  logic rec_pos;
  logic rec_neg;
  logic clk_out;
  logic pos_out;
  logic neg_out;

  modport core (
    output launch_on_fall,
    output rec_clk_en,
    output rec_pos,
    output rec_neg,
    input  clk_out,
    input  pos_out,
    input  neg_out
  );

  modport stage (
    input  launch_on_fall,
    input  rec_clk_en,
    input  rec_pos,
    input  rec_neg,
    output clk_out,
    output pos_out,
    output neg_out
  );
endinterface : lpd_launch_if
`default_nettype wire

// file: hdl/lpd_rx_launch.sv
// Receive launch stage: recovered clock output and edge-selected data
`timescale 1ns/1ps
`default_nettype none
`include "lpd_defines.svh"
module lpd_rx_launch (
  input  wire logic    clk_sys,
  input  wire logic    rst_n,
  lpd_launch_if.stage  lnk
);
  import lpd_pkg::*;

  logic clk_q;
  logic pos_q;
  logic neg_q;
  logic next_clk_q;
  logic next_pos_q;
  logic next_neg_q;

  // ----------------------------------------------------------------
  // Clock phase toggle and data launch
  // ----------------------------------------------------------------
  // Each enable toggles the output clock; data moves with the chosen
  // edge so the far end samples half a period away from any change.
  always_comb begin
    next_clk_q = clk_q;
    next_pos_q = pos_q;
    next_neg_q = neg_q;
    if (lnk.rec_clk_en) begin
      next_clk_q = ~clk_q;
      if (next_clk_q != lnk.launch_on_fall) begin // [R3] [R4]
        next_pos_q = lnk.rec_pos;
        next_neg_q = lnk.rec_neg;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_q <= 1'b0;
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end else begin
      clk_q <= next_clk_q;
      pos_q <= next_pos_q;
      neg_q <= next_neg_q;
    end
  end

  assign lnk.clk_out = clk_q;
  assign lnk.pos_out = pos_q;
  assign lnk.neg_out = neg_q;

endmodule : lpd_rx_launch
`default_nettype wire

// file: hdl/lpd_top.sv
// Static pin mode decode for the line interface unit
`timescale 1ns/1ps
`default_nettype none
`include "lpd_defines.svh"
module lpd_top #(
  parameter int CFG_W = `LPD_CFG_W
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // Configuration pins
  input  wire logic                 host_or_pin_mode_select,
  input  wire logic                 config_register_clear,
  input  wire logic                 config_register_clear_driven,
  input  wire logic                 near_loopback_select,
  input  wire logic                 far_loopback_select,
  input  wire logic                 rx_equalizer_off,
  input  wire logic                 signal_loss_threshold_select,
  input  wire logic                 e3_rate_select,
  input  wire logic                 sts1_rate_select,
  // Host command configuration from the serial interface
  input  wire logic                 host_cfg_write,
  input  wire logic [CFG_W-1:0]     host_cfg_data,
  // Recovered receive path, same clock
  input  wire logic                 rec_clk_en,
  input  wire logic                 rec_pos,
  input  wire logic                 rec_neg,
  // Decoded controls
  output logic                      host_mode,
  output lpd_pkg::lpd_rate_type     line_rate,
  output lpd_pkg::lpd_loop_type     loopback_mode,
  output logic                      analog_local_loopback,
  output logic                      digital_local_loopback,
  output logic                      remote_loopback,
  output logic                      equalizer_enable,
  output logic                      los_threshold_alt,
  output logic                      cmd_regs_clearing,
  output logic [CFG_W-1:0]          host_cfg,
  // Receive outputs
  output logic                      recovered_clock_out,
  output logic                      rx_positive_data,
  output logic                      rx_negative_data
);
  import lpd_pkg::*;

  // ----------------------------------------------------------------
  // Pin conditioning
  // ----------------------------------------------------------------
  logic [`LPD_NPINS-1:0] pin_raw;
  logic [`LPD_NPINS-1:0] sync_a;
  logic [`LPD_NPINS-1:0] sync_b;
  logic [`LPD_NPINS-1:0] next_sync_a;
  logic [`LPD_NPINS-1:0] next_sync_b;

  // An undriven clear pin reads high, as the internal pull-up would
  always_comb begin
    pin_raw                   = '0;
    pin_raw[`LPD_PIN_HOST]    = host_or_pin_mode_select;
    pin_raw[`LPD_PIN_CLEAR]   = config_register_clear_driven ?
                                config_register_clear : 1'b1; // [R2]
    pin_raw[`LPD_PIN_NEAR]    = near_loopback_select;
    pin_raw[`LPD_PIN_FAR]     = far_loopback_select;
    pin_raw[`LPD_PIN_EQOFF]   = rx_equalizer_off;
    pin_raw[`LPD_PIN_THR]     = signal_loss_threshold_select;
    pin_raw[`LPD_PIN_E3]      = e3_rate_select;
    pin_raw[`LPD_PIN_STS1]    = sts1_rate_select;
  end

  // ----------------------------------------------------------------
  // Two-stage synchronisers, one per pin
  // ----------------------------------------------------------------
  // Straps are asynchronous to clk_sys; the first stage feeds
  // only the second so a metastable sample never reaches decode.
  localparam logic [`LPD_NPINS-1:0] PINS_RESET = `LPD_PINS_RESET;

  genvar gi;
  generate
    for (gi = 0; gi < `LPD_NPINS; gi++) begin : g_sync
      always_comb begin
        next_sync_a[gi] = pin_raw[gi];
        next_sync_b[gi] = sync_a[gi];
      end

      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          sync_a[gi] <= PINS_RESET[gi];
          sync_b[gi] <= PINS_RESET[gi];
        end else begin
          sync_a[gi] <= next_sync_a[gi];
          sync_b[gi] <= next_sync_b[gi];
        end
      end
    end
  endgenerate

  logic s_host;
  logic s_clear_n;
  logic s_near;
  logic s_far;
  logic s_eqoff;
  logic s_thr;
  logic s_e3;
  logic s_sts1;

  // Clean views of the conditioned pins
  assign s_host    = sync_b[`LPD_PIN_HOST];
  assign s_clear_n = sync_b[`LPD_PIN_CLEAR];
  assign s_near    = sync_b[`LPD_PIN_NEAR];
  assign s_far     = sync_b[`LPD_PIN_FAR];
  assign s_eqoff   = sync_b[`LPD_PIN_EQOFF];
  assign s_thr     = sync_b[`LPD_PIN_THR];
  assign s_e3      = sync_b[`LPD_PIN_E3];
  assign s_sts1    = sync_b[`LPD_PIN_STS1];

  // ----------------------------------------------------------------
  // Host command configuration
  // ----------------------------------------------------------------
  logic [CFG_W-1:0] cfg;
  logic [CFG_W-1:0] next_cfg;
  logic             clearing;
  logic             next_clearing;

  // Clear beats a write in the same cycle: software must not see a
  // half-restored word once the pin has been pulled low.
  always_comb begin
    next_cfg      = cfg;
    next_clearing = 1'b0;
    if (s_host && !s_clear_n) begin
      next_cfg      = CFG_W'(`LPD_CFG_DEFAULT); // [R1]
      next_clearing = 1'b1;
    end else if (s_host && host_cfg_write) begin
      next_cfg      = host_cfg_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg      <= CFG_W'(`LPD_CFG_DEFAULT);
      clearing <= 1'b0;
    end else begin
      cfg      <= next_cfg;
      clearing <= next_clearing;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic         near_eff;
  logic         far_eff;
  logic         eqoff_eff;
  logic         thr_eff;
  logic         inv_eff;
  lpd_rate_type rate_eff;

  // Host mode takes its view from the command word, so the
  // equalizer and near loopback pins have no say there.
  always_comb begin
    if (s_host) begin // [R11]
      near_eff  = cfg[`LPD_CFG_NEAR]; // [R9]
      far_eff   = cfg[`LPD_CFG_FAR];
      eqoff_eff = cfg[`LPD_CFG_EQOFF]; // [R9]
      inv_eff   = cfg[`LPD_CFG_RCLKINV];
    end else begin
      near_eff  = s_near;
      far_eff   = s_far;
      eqoff_eff = s_eqoff; // [R5]
      inv_eff   = s_clear_n; // [R3] [R4]
    end
    thr_eff = s_thr;
    if (s_host) begin
      thr_eff = cfg[`LPD_CFG_THR];
    end
    if (s_e3) begin
      rate_eff = LPD_RATE_E3;
    end else if (s_sts1) begin
      rate_eff = LPD_RATE_STS1;
    end else begin
      rate_eff = LPD_RATE_DS3;
    end
  end

  // ----------------------------------------------------------------
  // Registered controls
  // ----------------------------------------------------------------
  lpd_loop_type loop_q;
  lpd_loop_type next_loop;
  lpd_rate_type rate_q;
  logic         host_q;
  logic         eq_en_q;
  logic         thr_q;
  logic         inv_q;
  logic         next_eq_en;
  logic         next_thr;

  always_comb begin
    case ({near_eff, far_eff})
      2'b10:   next_loop = LPD_LOOP_ANALOG; // [R7]
      2'b11:   next_loop = LPD_LOOP_DIGITAL; // [R8]
      2'b01:   next_loop = LPD_LOOP_REMOTE; // [R10]
      default: next_loop = LPD_LOOP_NONE; // [R12]
    endcase
    next_eq_en = ~eqoff_eff; // [R5]
    // E3 has a single fixed threshold pair, so the select is dropped
    next_thr   = (rate_eff != LPD_RATE_E3) && thr_eff; // [R6]
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loop_q  <= LPD_LOOP_NONE;
      rate_q  <= LPD_RATE_DS3;
      host_q  <= 1'b0;
      eq_en_q <= 1'b1;
      thr_q   <= 1'b0;
      inv_q   <= 1'b0;
    end else begin
      loop_q  <= next_loop;
      rate_q  <= rate_eff;
      host_q  <= s_host;
      eq_en_q <= next_eq_en;
      thr_q   <= next_thr;
      inv_q   <= inv_eff;
    end
  end

  // ----------------------------------------------------------------
  // Receive launch stage
  // ----------------------------------------------------------------
  lpd_launch_if lnk ();

  assign lnk.launch_on_fall = inv_q; // [R3] [R4]
  assign lnk.rec_clk_en     = rec_clk_en;
  assign lnk.rec_pos        = rec_pos;
  assign lnk.rec_neg        = rec_neg;

  lpd_rx_launch u_launch (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .lnk     (lnk)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign host_mode              = host_q;
  assign line_rate              = rate_q;
  assign loopback_mode          = loop_q;
  assign analog_local_loopback  = (loop_q == LPD_LOOP_ANALOG);
  assign digital_local_loopback = (loop_q == LPD_LOOP_DIGITAL);
  assign remote_loopback        = (loop_q == LPD_LOOP_REMOTE);
  assign equalizer_enable       = eq_en_q;
  assign los_threshold_alt      = thr_q;
  assign cmd_regs_clearing      = clearing;
  assign host_cfg               = cfg;
  assign recovered_clock_out    = lnk.clk_out;
  assign rx_positive_data       = lnk.pos_out;
  assign rx_negative_data       = lnk.neg_out;

endmodule : lpd_top
`default_nettype wire

// file: verification/lpd_top_sva.sv
// Checker of the decoded outputs against the configuration pins
`timescale 1ns/1ps
`default_nettype none
`include "lpd_defines.svh"
module lpd_top_sva #(
  parameter int CFG_W = `LPD_CFG_W
) (
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  input wire logic                  host_or_pin_mode_select,
  input wire logic                  config_register_clear,
  input wire logic                  config_register_clear_driven,
  input wire logic                  near_loopback_select,
  input wire logic                  far_loopback_select,
  input wire logic                  rx_equalizer_off,
  input wire logic                  signal_loss_threshold_select,
  input wire logic                  e3_rate_select,
  input wire logic                  rec_pos,
  input wire logic                  rec_neg,
  input wire logic                  host_mode,
  input wire lpd_pkg::lpd_loop_type loopback_mode,
  input wire logic                  equalizer_enable,
  input wire logic                  los_threshold_alt,
  input wire logic                  cmd_regs_clearing,
  input wire logic [CFG_W-1:0]      host_cfg,
  input wire logic                  recovered_clock_out,
  input wire logic                  rx_positive_data,
  input wire logic                  rx_negative_data
);
  import lpd_pkg::*;
  logic [1:0] rc;
  logic [1:0] next_rc;
  logic       clr_hi;
  // Settle count, so that $past never reaches back into reset
  always_comb begin
    next_rc = (rc == 2'h3) ? rc : rc + 2'h1;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rc <= 2'h0;
    end else begin
      rc <= next_rc;
    end
  end
  // Level seen inside, pull-up included
  assign clr_hi = config_register_clear | ~config_register_clear_driven;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // Decode checks: pins three edges after a change, host word one edge after
  // ------------------------------------------------------------
  a_host_follow:
    assert property (rc == 2'h3 |-> host_mode == $past(host_or_pin_mode_select, 3))
    else $error("host mode differs from its pin");
  a_loop_decode:
    assert property (rc == 2'h3 && !host_mode |->
      loopback_mode == {$past(near_loopback_select, 3), $past(far_loopback_select, 3)})
    else $error("loopback mode differs from pins");
  a_eq_pin:
    assert property (rc == 2'h3 && !host_mode |-> equalizer_enable == !$past(rx_equalizer_off, 3))
    else $error("equalizer enable differs from pin");
  a_eq_host_cfg:
    assert property (rc == 2'h3 && host_mode |-> equalizer_enable == !$past(host_cfg[`LPD_CFG_EQOFF]))
    else $error("equalizer enable ignores host word");
  a_thr_pin:
    assert property (rc == 2'h3 && !host_mode |->
      los_threshold_alt == ($past(signal_loss_threshold_select, 3) & ~$past(e3_rate_select, 3)))
    else $error("threshold select wrong");
  a_clear_zero:
    assert property (cmd_regs_clearing |-> host_cfg == '0)
    else $error("host word not cleared");
  a_float_quiet:
    assert property (rc == 2'h3 && !$past(config_register_clear_driven, 2)
      && !$past(config_register_clear_driven, 3) |-> !cmd_regs_clearing)
    else $error("floating clear pin clears");
  // Edge select reaches the launch stage one register later than the
  // other controls, so mode and invert level are taken four edges back
  a_rise_launch:
    assert property (rc == 2'h3 && $past(rc) == 2'h3
      && !$past(host_or_pin_mode_select, 4) && !$past(clr_hi, 4)
      && $rose(recovered_clock_out) |->
      rx_positive_data == $past(rec_pos) && rx_negative_data == $past(rec_neg))
    else $error("data not launched on rise");
  a_fall_launch:
    assert property (rc == 2'h3 && $past(rc) == 2'h3
      && !$past(host_or_pin_mode_select, 4) && $past(clr_hi, 4)
      && $fell(recovered_clock_out) |->
      rx_positive_data == $past(rec_pos) && rx_negative_data == $past(rec_neg))
    else $error("data not launched on fall");
endmodule : lpd_top_sva
bind lpd_top lpd_top_sva #(.CFG_W(CFG_W)) u_sva (.*);
`default_nettype wire

// file: verification/lpd_strap_model.sv
// Board strap model driving the configuration pins
`timescale 1ns/1ps
`default_nettype none
module lpd_strap_model (
  input  wire logic [8:0] want,
  output var logic        host_or_pin_mode_select,
  output var logic        config_register_clear,
  output var logic        config_register_clear_driven,
  output var logic        near_loopback_select,
  output var logic        far_loopback_select,
  output var logic        rx_equalizer_off,
  output var logic        signal_loss_threshold_select,
  output var logic        e3_rate_select,
  output var logic        sts1_rate_select
);
  logic last_clr = 1'b1;
  // Straps follow the request, near and equalizer-off tied low in host mode; an undriven clear pin drifts away from its last level
  always_comb begin
    {sts1_rate_select, e3_rate_select, signal_loss_threshold_select, rx_equalizer_off,
     far_loopback_select, near_loopback_select, config_register_clear_driven} = want[8:2];
    host_or_pin_mode_select = want[0];
    config_register_clear = want[2] ? want[1] : ~last_clr;
    if (want[0]) begin
      near_loopback_select = 1'b0;
      rx_equalizer_off = 1'b0;
    end
  end
  // Last driven clear level
  always @(want) begin
    if (want[2]) begin
      last_clr = want[1];
    end
  end
endmodule : lpd_strap_model
`default_nettype wire

// file: verification/line_unit_pin_mode_decode_test.sv
// Self-checking bench of the pin mode decode block
`timescale 1ns/1ps
`default_nettype none
`include "lpd_defines.svh"
module line_unit_pin_mode_decode_test;
  import lpd_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] want = 9'h006; // {sts1,e3,thr,eq,far,near,drv,clr,host}
  logic host_cfg_write = 1'b0;
  logic [`LPD_CFG_W-1:0] host_cfg_data = '0;
  logic rec_clk_en = 1'b0, rec_pos = 1'b0, rec_neg = 1'b0;
  logic host_or_pin_mode_select, config_register_clear, config_register_clear_driven;
  logic near_loopback_select, far_loopback_select, rx_equalizer_off;
  logic signal_loss_threshold_select, e3_rate_select, sts1_rate_select;
  logic host_mode, analog_local_loopback, digital_local_loopback, remote_loopback;
  lpd_rate_type line_rate;
  lpd_loop_type loopback_mode;
  logic equalizer_enable, los_threshold_alt, cmd_regs_clearing;
  logic [`LPD_CFG_W-1:0] host_cfg, w;
  logic recovered_clock_out, rx_positive_data, rx_negative_data;
  logic [10:0] seen;
  logic [7:0] lfsr = 8'h29;
  logic ck = 1'b0, dp = 1'b0, dn = 1'b0;
  int n_tests = 0, error_cnt = 0;
  lpd_strap_model straps (.*);
  lpd_top uut (.*);
  assign seen = {line_rate, loopback_mode, analog_local_loopback, digital_local_loopback,
                 remote_loopback, equalizer_enable, los_threshold_alt, host_mode, cmd_regs_clearing};
  always #12.5 clk_sys = ~clk_sys;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr_next
  // Expected pin-mode decode, packed like seen
  function automatic logic [10:0] exp_hw(input logic [8:0] v);
    logic [1:0] rt;
    rt = v[7] ? 2'b10 : {1'b0, v[8]};
    return {rt, v[3], v[4], v[3] & ~v[4], v[3] & v[4], v[4] & ~v[3], ~v[5], v[6] & ~v[7], 2'b00};
  endfunction : exp_hw
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Inputs always move 2 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (12) @(posedge clk_sys);
    #2;
    rst_n = 1'b1;
    // Pin mode: every loopback code, E3 masking the threshold, a change every four edges
    for (int i = 0; i < 16; i++) begin
      lfsr = lfsr_next(lfsr);
      want = {lfsr[0], i[2], i[3], lfsr[1], i[0], i[1], 3'b110};
      tick(4);
      chk(seen, exp_hw(want));
    end
    $display("test pin decode done");
    // Launch edge picked by the clear pin, enables partly back to back
    for (int inv = 0; inv < 2; inv++) begin
      want = {6'h00, 1'b1, inv[0], 1'b0}; // Clear pin driven to the invert level
      tick(4);
      for (int k = 0; k < 12; k++) begin
        lfsr = lfsr_next(lfsr);
        {rec_clk_en, rec_pos, rec_neg} = {lfsr[2] | (k < 3), lfsr[1:0]};
        tick(1);
        if (rec_clk_en) begin
          ck = ~ck;
          if (ck != inv[0]) begin
            {dp, dn} = {rec_pos, rec_neg};
          end
        end
        chk(11'({recovered_clock_out, rx_positive_data, rx_negative_data}), 11'({ck, dp, dn}));
      end
      rec_clk_en = 1'b0;
    end
    $display("test launch edge done");
    // Host mode: back-to-back writes, far pin ignored
    want = {4'h0, lfsr[3], 4'b0111};
    tick(4);
    for (int k = 0; k < 6; k++) begin
      lfsr = lfsr_next(lfsr);
      w = lfsr[4:0];
      host_cfg_write = 1'b1;
      host_cfg_data = w;
      tick(1);
      chk(11'(host_cfg), 11'(w));
    end
    host_cfg_write = 1'b0;
    tick(1);
    chk(11'({loopback_mode, equalizer_enable, los_threshold_alt, host_mode}),
        11'({w[1], w[0], ~w[2], w[4], 1'b1}));
    // Clear low wins over a write
    want[1] = 1'b0;
    tick(4);
    host_cfg_write = 1'b1;
    host_cfg_data = 5'h1f;
    tick(1);
    host_cfg_write = 1'b0;
    tick(1);
    chk(11'({cmd_regs_clearing, host_cfg}), 11'h020);
    // Released clear pin floating low must still read high
    want[1] = 1'b1;
    tick(4);
    want[2] = 1'b0;
    tick(4);
    chk(11'(cmd_regs_clearing), 11'h000);
    $display("test host mode done");
    conclude();
  end
endmodule : line_unit_pin_mode_decode_test
`default_nettype wire
